// file: tsfc_pkg.sv
// tsfc_pkg: offsets, field positions, reset values and types of the
// transport stream filter control and interrupt enable block.
// assumes a plain register port with byte addresses, 32-bit words.
package tsfc_pkg;
    localparam int ADDR_W = 8;
    localparam int PID_W  = 13;
    localparam int SLOTS  = 8;
    localparam int SLOT_W = 3;

    // register byte addresses
    localparam logic [7:0] OFF_CTRL0    = 8'h00;
    localparam logic [7:0] OFF_STREAM_CONTROL_SECOND    = 8'h04;
    localparam logic [7:0] OFF_INTERRUPT_SOURCE_ENABLE    = 8'h08;
    localparam logic [7:0] OFF_ARM      = 8'h0C;
    localparam logic [7:0] OFF_STALL    = 8'h10;
    localparam logic [7:0] OFF_STAT     = 8'h14;
    localparam logic [7:0] OFF_STAT_CLR = 8'h18;
    localparam logic [7:0] OFF_MAP_PID  = 8'h1C;
    localparam logic [7:0] OFF_BND_PID  = 8'h20;
    localparam logic [2:0] TABLE_PAGE   = 3'h2;

    // first receive control register
    localparam int C0_RUN    = 0;
    localparam int C0_DMA    = 1;
    localparam int C0_TSMODE = 5;
    localparam logic [31:0] CTRL0_MASK = 32'h0000_0023;

    // second stream control register
    localparam int C1_GIE  = 15;
    localparam int C1_CRC  = 12;
    localparam int C1_TEI  = 9;
    localparam int C1_SYNC = 8;
    localparam int C1_GOP  = 5;
    localparam int C1_BND  = 4;
    localparam int C1_PFE  = 3;
    localparam int C1_MODE = 0;
    localparam logic [31:0] STREAM_CONTROL_SECOND_MASK = 32'h0000_933F;

    // interrupt source bits
    localparam int IB_TIMER = 16;
    localparam int IB_WRING = 8;
    localparam int IB_RXERR = 6;
    localparam int IB_RRING = 4;
    localparam int IB_MAP   = 3;
    localparam int IB_ASSOC = 2;
    localparam int IB_GOP   = 1;
    localparam int IB_BOUND = 0;
    localparam logic [31:0] INT_MASK = 32'h00FF_FF5F;

    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [PID_W-1:0] PID_RESET = 13'h0000;

    localparam logic [2:0] MODE_MANUAL = 3'h0;
    localparam logic [2:0] MODE_SEMI_A = 3'h1;
    localparam logic [2:0] MODE_SEMI_B = 3'h2;
    localparam logic [2:0] MODE_AUTO   = 3'h3;

    typedef enum logic [2:0] {
        FS_WAIT_ASSOC = 3'b001,
        FS_WAIT_MAP   = 3'b010,
        FS_RUN        = 3'b100
    } tsfc_fsm_e;

    function automatic logic [31:0] tsfc_bit(input int idx, input logic on);
        tsfc_bit = 32'h0000_0000;
        tsfc_bit[idx] = on;
    endfunction : tsfc_bit
endpackage : tsfc_pkg

// file: tsfc_pid_table.sv
// tsfc_pid_table: per-slot packet identifier table, one write port and
// two registered read ports (packet lookup and register readback).
// assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
module tsfc_pid_table #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 13
) (
    // clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // write port
    input  wire logic                     we_i,
    input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
    input  wire logic [WIDTH-1:0]         wdata_i,
    // read ports
    input  wire logic [$clog2(DEPTH)-1:0] raddr_a_i,
    input  wire logic [$clog2(DEPTH)-1:0] raddr_b_i,
    output logic      [WIDTH-1:0]         rdata_a_o,
    output logic      [WIDTH-1:0]         rdata_b_o
);
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
        $error("tsfc_pid_table: DEPTH must be 2 or more, WIDTH 1 or more");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0]            rd_a;
        logic [WIDTH-1:0]            rd_b;
    } tsfc_tbl_s;

    tsfc_tbl_s st;
    tsfc_tbl_s next_st;

    always_comb begin
        next_st = st;
        // read before write: a lookup in the write cycle sees the old entry
        next_st.rd_a = st.mem[raddr_a_i];
        next_st.rd_b = st.mem[raddr_b_i];
        if (we_i) begin
            next_st.mem[waddr_i] = wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_a_o = st.rd_a;
    assign rdata_b_o = st.rd_b;
endmodule : tsfc_pid_table

// file: tsfc_ctrl.sv
// tsfc_ctrl: packet identifier filter control and interrupt enable
// gating of a transport stream receive port, with its register port.
// assumes packet header fields arrive decoded, one packet per cycle.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
// Function
// - with filtering on and checksum filter on, bad table sections are dropped
// - with filtering on and error filter on, error-flagged packets are dropped
// - with filtering on and sync filter on, sync-error packets are dropped
// - picture group start flagged when start indicator and priority both one
// - boundary method: 0 discontinuity table, 1 packet with programmed identifier
// - filter enable acts only in transport mode; 0 means bypass
// - three-bit mode field: manual, semi A, semi B, automatic; 4-7 reserved
// - manual mode decodes no tables; identifiers all come from software
// - mode A raises association detect on each association table
// - mode A flags map table detect; software then loads filters and enables
// - mode A boundary pulses interrupt and returns to waiting for association
// - mode B parses only once both receive enable bits read one
// - modes B and automatic replace a slot entry with a newly seen identifier
// - automatic mode takes the map identifier from decoded association data
// - source interrupts only when set in both enable and arm registers
// - writing one to stall holds a source back without touching its enable
// - an arm bit is ignored while its enable bit is zero
// - the arm register is never cleared as a side effect
// - source bit layout: timers 23-16, write rings 15-8, then 6,4,3,2,1,0
// - global interrupt enable in bit 15 gates every interrupt
// - receive transport mode bit enables all filtering functions
// - status bits record events whatever the enables say
module tsfc_ctrl
    import tsfc_pkg::*;
(
    // clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // register port
    input  wire logic [tsfc_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [31:0]                wdata_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic      [31:0]                rdata_o,
    // decoded packet header
    input  wire logic                       pkt_valid_i,
    input  wire logic [tsfc_pkg::PID_W-1:0] pkt_pid_i,
    input  wire logic [tsfc_pkg::SLOT_W-1:0] pkt_slot_i,
    input  wire logic                       pkt_tei_i,
    input  wire logic                       pkt_sync_err_i,
    input  wire logic                       pkt_pusi_i,
    input  wire logic                       pkt_prio_i,
    input  wire logic                       pkt_is_assoc_i,
    input  wire logic                       pkt_is_map_i,
    input  wire logic                       pkt_is_dit_i,
    input  wire logic                       pkt_crc_ok_i,
    // table decoder results
    input  wire logic [tsfc_pkg::PID_W-1:0] assoc_map_pid_i,
    input  wire logic                       es_valid_i,
    input  wire logic [tsfc_pkg::SLOT_W-1:0] es_slot_i,
    input  wire logic [tsfc_pkg::PID_W-1:0] es_pid_i,
    // other interrupt sources
    input  wire logic [7:0]                 timer_match_i,
    input  wire logic [7:0]                 write_ring_i,
    input  wire logic                       read_ring_i,
    input  wire logic                       rx_pkt_err_i,
    // results
    output logic                            pkt_pass_o,
    output logic                            pkt_drop_o,
    output logic                            group_start_o,
    output logic                            irq_o
);
    import tsfc_pkg::*;

    typedef struct packed {
        logic [31:0]      ctrl0;
        logic [31:0]      stream_control_second;
        logic [31:0]      en;
        logic [31:0]      arm;
        logic [31:0]      stall;
        logic [31:0]      stat;
        logic [PID_W-1:0] map_pid;
        logic [PID_W-1:0] bnd_pid;
        logic [PID_W-1:0] auto_pid;
        tsfc_fsm_e        fsm;
        logic             s1_v;
        logic             s1_bypass;
        logic             s1_err;
        logic             s1_hold;
        logic             s1_tbl;
        logic [PID_W-1:0] s1_pid;
        logic             pass;
        logic             drop;
        logic             gop;
        logic             irq;
        logic             rd_tbl;
        logic [31:0]      rdata;
    } tsfc_state_s;

    tsfc_state_s st;
    tsfc_state_s next_st;

    logic [2:0]       mode;
    logic             filt_on;
    logic             parse_on;
    logic             err_pkt;
    logic             act;
    logic             bnd_hit;
    logic             gop_hit;
    logic             assoc_hit;
    logic             map_hit;
    logic [PID_W-1:0] cur_map;
    logic             tbl_sel;
    logic             es_we;
    logic             tbl_we;
    logic [PID_W-1:0] tbl_a;
    logic [PID_W-1:0] tbl_b;
    logic [31:0]      set_bits;
    logic [31:0]      clr_bits;
    logic [31:0]      live;

    assign mode    = st.stream_control_second[C1_MODE +: 3];
    // reserved mode codes fall back to bypass rather than guess a mode
    assign filt_on = st.ctrl0[C0_TSMODE] & st.stream_control_second[C1_PFE] & ~mode[2];
    assign parse_on = ((mode != MODE_SEMI_B) && (mode != MODE_AUTO))
                    || (st.ctrl0[C0_DMA:C0_RUN] == 2'b11);
    assign err_pkt = (st.stream_control_second[C1_CRC] & (pkt_is_assoc_i | pkt_is_map_i) & ~pkt_crc_ok_i)
                   | (st.stream_control_second[C1_TEI] & pkt_tei_i)
                   | (st.stream_control_second[C1_SYNC] & pkt_sync_err_i);
    assign act     = pkt_valid_i & filt_on & ~err_pkt;
    assign cur_map = (mode == MODE_AUTO) ? st.auto_pid : st.map_pid;
    assign bnd_hit = act & (st.stream_control_second[C1_BND] ? (pkt_pid_i == st.bnd_pid) : pkt_is_dit_i);
    assign gop_hit = act & st.stream_control_second[C1_GOP] & pkt_pusi_i & pkt_prio_i;
    // manual mode never looks at program tables
    assign assoc_hit = act & (mode != MODE_MANUAL) & pkt_is_assoc_i;
    assign map_hit = act & (mode != MODE_MANUAL) & pkt_is_map_i & (pkt_pid_i == cur_map)
                   & ~((mode == MODE_SEMI_A) && (st.fsm == FS_WAIT_ASSOC));
    assign tbl_sel = (addr_i[7:5] == TABLE_PAGE);
    // decoder updates win over a software write in the same cycle
    assign es_we   = es_valid_i & filt_on & parse_on
                   & ((mode == MODE_SEMI_B) || (mode == MODE_AUTO));
    assign tbl_we  = es_we | (wr_i & tbl_sel);

    tsfc_pid_table #(
        .DEPTH (SLOTS),
        .WIDTH (PID_W)
    ) u_table (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .we_i      (tbl_we),
        .waddr_i   (es_we ? es_slot_i : addr_i[4:2]),
        .wdata_i   (es_we ? es_pid_i : wdata_i[PID_W-1:0]),
        .raddr_a_i (pkt_slot_i),
        .raddr_b_i (addr_i[4:2]),
        .rdata_a_o (tbl_a),
        .rdata_b_o (tbl_b)
    );

    always_comb begin
        set_bits = ({8'h00, timer_match_i, 16'h0000} | {16'h0000, write_ring_i, 8'h00})
                 | tsfc_bit(IB_RRING, read_ring_i) | tsfc_bit(IB_RXERR, rx_pkt_err_i)
                 | tsfc_bit(IB_BOUND, bnd_hit) | tsfc_bit(IB_GOP, gop_hit)
                 | tsfc_bit(IB_ASSOC, assoc_hit) | tsfc_bit(IB_MAP, map_hit);
        clr_bits = (wr_i && addr_i == OFF_STAT_CLR) ? wdata_i : 32'h0000_0000;
    end

    // a source is live only when enabled, armed, not stalled
    assign live = st.stat & st.en & st.arm & ~st.stall;

    always_comb begin
        next_st = st;
        // new events win over a clear in the same cycle
        next_st.stat = ((st.stat & ~clr_bits) | set_bits) & INT_MASK;
        next_st.irq  = st.stream_control_second[C1_GIE] & (|live);

        if (wr_i) begin
            unique case (addr_i)
                OFF_CTRL0:   next_st.ctrl0 = wdata_i & CTRL0_MASK;
                OFF_STREAM_CONTROL_SECOND:   next_st.stream_control_second = wdata_i & STREAM_CONTROL_SECOND_MASK;
                OFF_INTERRUPT_SOURCE_ENABLE:   next_st.en    = wdata_i & INT_MASK;
                OFF_ARM: begin
                    // re-arming a source releases its stall
                    next_st.arm   = wdata_i & INT_MASK;
                    next_st.stall = st.stall & ~wdata_i;
                end
                OFF_STALL:   next_st.stall = st.stall | (wdata_i & st.en & st.arm & INT_MASK);
                OFF_MAP_PID: next_st.map_pid = wdata_i[PID_W-1:0];
                OFF_BND_PID: next_st.bnd_pid = wdata_i[PID_W-1:0];
                default:     next_st.ctrl0 = st.ctrl0;
            endcase
        end

        if (assoc_hit && mode == MODE_AUTO) begin
            next_st.auto_pid = assoc_map_pid_i;
        end

        if (mode != MODE_SEMI_A || !filt_on) begin
            next_st.fsm = FS_WAIT_ASSOC;
        end else if (bnd_hit) begin
            next_st.fsm = FS_WAIT_ASSOC;
        end else begin
            unique case (st.fsm)
                FS_WAIT_ASSOC: if (assoc_hit) next_st.fsm = FS_WAIT_MAP;
                FS_WAIT_MAP:   if (map_hit) next_st.fsm = FS_RUN;
                FS_RUN:        next_st.fsm = FS_RUN;
                default:       next_st.fsm = FS_WAIT_ASSOC;
            endcase
        end

        // stage 1: header checks while the slot entry is read
        next_st.s1_v      = pkt_valid_i;
        next_st.s1_bypass = ~filt_on;
        next_st.s1_err    = err_pkt;
        next_st.s1_hold   = ~parse_on | ((mode == MODE_SEMI_A) && (st.fsm != FS_RUN));
        next_st.s1_tbl    = (mode != MODE_MANUAL)
                          & (pkt_is_assoc_i | (pkt_is_map_i & (pkt_pid_i == cur_map)));
        next_st.s1_pid    = pkt_pid_i;

        // stage 2: verdict against the slot entry
        next_st.pass = 1'b0;
        next_st.drop = 1'b0;
        if (st.s1_v) begin
            if (st.s1_bypass) begin
                next_st.pass = 1'b1;
            end else if (st.s1_err || st.s1_hold && !st.s1_tbl) begin
                next_st.drop = 1'b1;
            end else if (st.s1_tbl || tbl_a == st.s1_pid) begin
                next_st.pass = 1'b1;
            end else begin
                next_st.drop = 1'b1;
            end
        end
        next_st.gop = gop_hit;

        // register readback, stall register reads as zero
        next_st.rd_tbl = rd_i & tbl_sel;
        next_st.rdata  = 32'h0000_0000;
        if (rd_i) begin
            unique case (addr_i)
                OFF_CTRL0:   next_st.rdata = st.ctrl0;
                OFF_STREAM_CONTROL_SECOND:   next_st.rdata = st.stream_control_second;
                OFF_INTERRUPT_SOURCE_ENABLE:   next_st.rdata = st.en;
                OFF_ARM:     next_st.rdata = st.arm;
                OFF_STAT:    next_st.rdata = st.stat;
                OFF_MAP_PID: next_st.rdata = {19'h00000, st.map_pid};
                OFF_BND_PID: next_st.rdata = {19'h00000, st.bnd_pid};
                default:     next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st       <= '0;
            st.fsm   <= FS_WAIT_ASSOC;
            st.stream_control_second <= REG_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o       = st.rd_tbl ? {19'h00000, tbl_b} : st.rdata;
    assign pkt_pass_o    = st.pass;
    assign pkt_drop_o    = st.drop;
    assign group_start_o = st.gop;
    assign irq_o         = st.irq;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_crc_drop: assert property (pkt_valid_i && filt_on && st.stream_control_second[C1_CRC] && pkt_is_map_i
        && !pkt_crc_ok_i |-> ##2 pkt_drop_o) else $error("bad checksum table packet not dropped");
    a_tei_drop: assert property (pkt_valid_i && filt_on && st.stream_control_second[C1_TEI] && pkt_tei_i
        |-> ##2 (pkt_drop_o && !pkt_pass_o)) else $error("transport error packet not dropped");
    a_sync_drop: assert property (pkt_valid_i && filt_on && st.stream_control_second[C1_SYNC] && pkt_sync_err_i
        |-> ##2 pkt_drop_o) else $error("sync error packet not dropped");
    a_gop_flag: assert property (group_start_o |-> $past(filt_on && pkt_pusi_i && pkt_prio_i)
        && st.stat[IB_GOP]) else $error("group start without cause");
    a_bypass_pass: assert property (pkt_valid_i && !st.ctrl0[C0_TSMODE]
        |-> ##2 pkt_pass_o) else $error("bypass packet not passed");
    a_bound_back: assert property (bnd_hit && mode == MODE_SEMI_A
        |=> st.fsm == FS_WAIT_ASSOC && st.stat[IB_BOUND]) else $error("boundary did not restart");
    a_irq_cause: assert property (irq_o |-> $past(st.stream_control_second[C1_GIE])
        && $past(|(st.stat & st.en & st.arm & ~st.stall))) else $error("interrupt without gated cause");
    a_stall_keeps: assert property (wr_i && addr_i == OFF_STALL && wdata_i[IB_MAP]
        && st.en[IB_MAP] && st.arm[IB_MAP] |=> st.stall[IB_MAP] && st.en[IB_MAP])
        else $error("stall write misbehaved");
    a_arm_ignored: assert property (!st.en[IB_GOP] && st.stat[IB_GOP] && !(|(live))
        |=> !irq_o) else $error("armed source fired with enable off");
    a_status_rec: assert property (timer_match_i[0] |=> st.stat[IB_TIMER])
        else $error("timer event not recorded");

    c_mode_a_run: cover property (mode == MODE_SEMI_A ##[1:20] st.fsm == FS_RUN);
    c_irq_fire: cover property (!irq_o ##1 irq_o);
    c_table_pass: cover property (pkt_pass_o && !st.s1_bypass);
endmodule : tsfc_ctrl

// file: tsfc_tb.sv
// tsfc_tb: self-checking bench for the stream filter control and interrupt gating.
// assumes tsfc_pkg and tsfc_ctrl are compiled first; one 10 MHz clock.
`timescale 1ns/1ps
module testbench;
    import tsfc_pkg::*;

    localparam logic [7:0] F_TEI = 8'h80, F_SYNC = 8'h40, F_PUSI = 8'h20, F_PRIO = 8'h10;
    localparam logic [7:0] F_ASSOC = 8'h08, F_MAP = 8'h04, F_DIT = 8'h02, F_OK = 8'h01;
    localparam logic [31:0] GIE = 32'h0000_8000, PFE = 32'h0000_0008;

    logic              clk_i, rst_i, wr_i, rd_i, pkt_valid_i, read_ring_i, rx_pkt_err_i;
    logic [ADDR_W-1:0] addr_i;
    logic [31:0]       wdata_i, rdata_o;
    logic [PID_W-1:0]  pkt_pid_i;
    logic [SLOT_W-1:0] pkt_slot_i;
    logic              pkt_tei_i, pkt_sync_err_i, pkt_pusi_i, pkt_prio_i;
    logic              pkt_is_assoc_i, pkt_is_map_i, pkt_is_dit_i, pkt_crc_ok_i;
    logic [7:0]        timer_match_i, write_ring_i;
    logic              es_valid_i;
    logic [SLOT_W-1:0] es_slot_i;
    logic [PID_W-1:0]  es_pid_i, assoc_map_pid_i;
    logic              pkt_pass_o, pkt_drop_o, group_start_o, irq_o;
    int                mismatches, compares;

    tsfc_ctrl tsfc_ctrl_i (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .pkt_valid_i(pkt_valid_i), .pkt_pid_i(pkt_pid_i), .pkt_slot_i(pkt_slot_i),
        .pkt_tei_i(pkt_tei_i), .pkt_sync_err_i(pkt_sync_err_i), .pkt_pusi_i(pkt_pusi_i),
        .pkt_prio_i(pkt_prio_i), .pkt_is_assoc_i(pkt_is_assoc_i), .pkt_is_map_i(pkt_is_map_i),
        .pkt_is_dit_i(pkt_is_dit_i), .pkt_crc_ok_i(pkt_crc_ok_i), .assoc_map_pid_i(assoc_map_pid_i),
        .es_valid_i(es_valid_i), .es_slot_i(es_slot_i), .es_pid_i(es_pid_i), .timer_match_i(timer_match_i),
        .write_ring_i(write_ring_i), .read_ring_i(read_ring_i), .rx_pkt_err_i(rx_pkt_err_i),
        .pkt_pass_o(pkt_pass_o), .pkt_drop_o(pkt_drop_o), .group_start_o(group_start_o), .irq_o(irq_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic end_sim;
        if (mismatches == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk($sformatf("reg_%h", a), rdata_o, exp);
    endtask : rd

    task automatic pkt(input logic [12:0] pid, input logic [2:0] slot, input logic [7:0] f,
                       input logic exp_pass, input logic exp_gs);
        @(posedge clk_i);
        pkt_valid_i <= 1'b1;
        pkt_pid_i <= pid;
        pkt_slot_i <= slot;
        {pkt_tei_i, pkt_sync_err_i, pkt_pusi_i, pkt_prio_i} <= f[7:4];
        {pkt_is_assoc_i, pkt_is_map_i, pkt_is_dit_i, pkt_crc_ok_i} <= f[3:0];
        @(posedge clk_i);
        pkt_valid_i <= 1'b0;
        #1 chk("group_start", group_start_o, exp_gs);
        @(posedge clk_i);
        #1 chk("pass", pkt_pass_o, exp_pass);
        chk("drop", pkt_drop_o, !exp_pass);
    endtask : pkt

    // one-cycle event pulse on the non-packet sources, then irq settles two edges later
    task automatic event_pulse(input logic [31:0] ev);
        @(posedge clk_i);
        timer_match_i <= ev[23:16];
        write_ring_i <= ev[15:8];
        rx_pkt_err_i <= ev[6];
        read_ring_i <= ev[4];
        @(posedge clk_i);
        {timer_match_i, write_ring_i, rx_pkt_err_i, read_ring_i} <= '0;
    endtask : event_pulse

    task automatic irq_is(input logic exp);
        repeat (2) @(posedge clk_i);
        #1 chk("irq", irq_o, exp);
    endtask : irq_is

    task automatic test_reset_and_masks;
        logic [7:0] offs [9];
        offs = '{OFF_CTRL0, OFF_STREAM_CONTROL_SECOND, OFF_INTERRUPT_SOURCE_ENABLE, OFF_ARM, OFF_STALL, OFF_STAT, OFF_MAP_PID, OFF_BND_PID, 8'h3C};
        foreach (offs[k]) rd(offs[k], 32'h0000_0000);
        wr(OFF_CTRL0, 32'hFFFF_FFFF);
        rd(OFF_CTRL0, 32'h0000_0023);
        wr(OFF_STREAM_CONTROL_SECOND, 32'hFFFF_FFFF);
        rd(OFF_STREAM_CONTROL_SECOND, 32'h0000_933F);
        wr(OFF_INTERRUPT_SOURCE_ENABLE, 32'hFFFF_FFFF);
        rd(OFF_INTERRUPT_SOURCE_ENABLE, 32'h00FF_FF5F);
        wr(OFF_ARM, 32'hFFFF_FFFF);
        rd(OFF_ARM, 32'h00FF_FF5F);
        wr(8'h3C, 32'hFFFF_FFFF);
        rd(8'h3C, 32'h0000_0000);
        foreach (offs[k]) wr(offs[k], 32'h0000_0000);
    endtask : test_reset_and_masks

    task automatic test_sources;
        for (int i = 4; i < 24; i++) begin
            if (INT_MASK[i]) begin
                event_pulse(32'h1 << i);
                rd(OFF_STAT, 32'h1 << i);
                wr(OFF_STAT_CLR, 32'h1 << i);
            end
        end
    endtask : test_sources

    task automatic test_gating;
        wr(OFF_STREAM_CONTROL_SECOND, GIE);
        wr(OFF_ARM, 32'h0001_0000);
        event_pulse(32'h0001_0000);
        irq_is(1'b0);
        wr(OFF_INTERRUPT_SOURCE_ENABLE, 32'h0001_0000);
        irq_is(1'b1);
        wr(OFF_STREAM_CONTROL_SECOND, 32'h0);
        irq_is(1'b0);
        wr(OFF_STREAM_CONTROL_SECOND, GIE);
        irq_is(1'b1);
        wr(OFF_STALL, 32'h0001_0000);
        irq_is(1'b0);
        rd(OFF_INTERRUPT_SOURCE_ENABLE, 32'h0001_0000);
        rd(OFF_STALL, 32'h0);
        wr(OFF_INTERRUPT_SOURCE_ENABLE, 32'h0);
        wr(OFF_INTERRUPT_SOURCE_ENABLE, 32'h0001_0000);
        rd(OFF_ARM, 32'h0001_0000);
        irq_is(1'b0);
        wr(OFF_ARM, 32'h0001_0000);
        irq_is(1'b1);
        wr(OFF_STAT_CLR, 32'hFFFF_FFFF);
        irq_is(1'b0);
    endtask : test_gating

    task automatic test_manual;
        wr(OFF_CTRL0, 32'h0000_0020);
        wr(8'h48, 32'h0000_0123);
        rd(8'h48, 32'h0000_0123);
        wr(OFF_STREAM_CONTROL_SECOND, 32'h0000_1320 | PFE);
        pkt(13'h0123, 3'h2, F_OK, 1'b1, 1'b0);
        pkt(13'h0124, 3'h2, F_OK, 1'b0, 1'b0);
        pkt(13'h0123, 3'h2, F_OK | F_TEI, 1'b0, 1'b0);
        pkt(13'h0123, 3'h2, F_OK | F_SYNC, 1'b0, 1'b0);
        pkt(13'h0123, 3'h2, F_OK | F_PUSI | F_PRIO, 1'b1, 1'b1);
        pkt(13'h0123, 3'h2, F_OK | F_PUSI, 1'b1, 1'b0);
        rd(OFF_STAT, 32'h0000_0002);
        wr(OFF_STAT_CLR, 32'hFFFF_FFFF);
        wr(OFF_STREAM_CONTROL_SECOND, 32'h0000_0305 | PFE);
        pkt(13'h0124, 3'h2, F_TEI, 1'b1, 1'b0);
        wr(OFF_STREAM_CONTROL_SECOND, 32'h0000_0300);
        pkt(13'h0124, 3'h2, F_TEI, 1'b1, 1'b0);
        wr(OFF_CTRL0, 32'h0000_0000);
        wr(OFF_STREAM_CONTROL_SECOND, 32'h0000_0300 | PFE);
        pkt(13'h0124, 3'h2, F_TEI, 1'b1, 1'b0);
    endtask : test_manual

    task automatic test_modes;
        wr(OFF_CTRL0, 32'h0000_0020);
        wr(OFF_MAP_PID, 32'h0000_0100);
        wr(OFF_STREAM_CONTROL_SECOND, 32'h0000_1001 | PFE);
        pkt(13'h0123, 3'h2, F_OK, 1'b0, 1'b0);
        pkt(13'h0000, 3'h0, F_ASSOC, 1'b0, 1'b0);
        rd(OFF_STAT, 32'h0);
        pkt(13'h0000, 3'h0, F_ASSOC | F_OK, 1'b1, 1'b0);
        pkt(13'h0100, 3'h0, F_MAP | F_OK, 1'b1, 1'b0);
        pkt(13'h0123, 3'h2, F_OK, 1'b1, 1'b0);
        // boundary packet 0777 does not match the slot 1 entry, so it is filtered out
        pkt(13'h0777, 3'h1, F_DIT | F_OK, 1'b0, 1'b0);
        rd(OFF_STAT, 32'h0000_000D);
        pkt(13'h0123, 3'h2, F_OK, 1'b0, 1'b0);
        wr(OFF_STAT_CLR, 32'hFFFF_FFFF);
        wr(OFF_STREAM_CONTROL_SECOND, 32'h0000_0002 | PFE);
        pkt(13'h0123, 3'h2, F_OK, 1'b0, 1'b0);
        wr(OFF_CTRL0, 32'h0000_0023);
        pkt(13'h0123, 3'h2, F_OK, 1'b1, 1'b0);
        pkt(13'h0055, 3'h3, F_OK, 1'b0, 1'b0);
        @(posedge clk_i);
        es_valid_i <= 1'b1;
        es_slot_i <= 3'h3;
        es_pid_i <= 13'h0055;
        @(posedge clk_i);
        es_valid_i <= 1'b0;
        pkt(13'h0055, 3'h3, F_OK, 1'b1, 1'b0);
        wr(OFF_STAT_CLR, 32'hFFFF_FFFF);
        wr(OFF_STREAM_CONTROL_SECOND, 32'h0000_0003 | PFE);
        assoc_map_pid_i <= 13'h00AA;
        pkt(13'h0000, 3'h0, F_ASSOC | F_OK, 1'b1, 1'b0);
        pkt(13'h00AA, 3'h0, F_MAP | F_OK, 1'b1, 1'b0);
        rd(OFF_STAT, 32'h0000_000C);
    endtask : test_modes

    initial begin
        mismatches = 0;
        compares = 0;
        rst_i = 1'b1;
        {wr_i, rd_i, pkt_valid_i, read_ring_i, rx_pkt_err_i} = '0;
        addr_i = '0;
        wdata_i = '0;
        pkt_pid_i = '0;
        pkt_slot_i = '0;
        {pkt_tei_i, pkt_sync_err_i, pkt_pusi_i, pkt_prio_i} = '0;
        {pkt_is_assoc_i, pkt_is_map_i, pkt_is_dit_i, pkt_crc_ok_i} = '0;
        timer_match_i = '0;
        write_ring_i = '0;
        es_valid_i = 1'b0;
        es_slot_i = '0;
        es_pid_i = '0;
        assoc_map_pid_i = '0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        test_reset_and_masks();
        test_sources();
        test_gating();
        test_manual();
        test_modes();
        end_sim();
    end

    // guards against a hung run
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        end_sim();
    end
endmodule : testbench
